// >>> pfs_pkg.sv
package pfs_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int STALE_TICK_NS  = 100000;
  localparam int STALE_TICK_CYC = STALE_TICK_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL   = 8'h30;
  localparam logic [7:0] IDX_PACC   = 8'h31;
  localparam logic [7:0] IDX_STATUS = 8'h32;
  localparam logic [7:0] IDX_DERR   = 8'h34;
  localparam logic [7:0] IDX_HOLD1  = 8'h35;
  localparam logic [7:0] IDX_HOLD2  = 8'h36;
  localparam logic [7:0] IDX_RUN    = 8'h37;
  localparam logic [7:0] IDX_LEVEL  = 8'h3a;
  localparam logic [7:0] IDX_THR    = 8'h3b;
  localparam logic [7:0] IDX_SPER   = 8'h3c;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int ST_FULL    = 7;
  localparam int ST_EMPTY   = 6;
  localparam int ST_TIMEOUT = 5;
  localparam int ST_TAG     = 4;
  localparam int ST_PDATA   = 3;
  localparam int ST_STALE   = 2;
  localparam int ST_LONE    = 1;
  localparam int ST_DERR    = 0;

  localparam int CTL_DMA_EN  = 0;
  localparam int CTL_DIR     = 1;
  localparam int CTL_SET_TAG = 2;
  localparam int CTL_RLE     = 3;
  localparam int CTL_TAG_IE  = 4;
  localparam int CTL_FRES    = 7;
  localparam int PACC_CLR_TO = 3;

  // ------------------------------------------------------------
  // reset and init values
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_RST      = 8'h00;
  localparam logic [7:0] PACC_RST      = 8'h00;
  localparam logic [6:0] THR_RST       = 7'h00;
  localparam logic [6:0] RUN_RST       = 7'h00;
  localparam logic [7:0] SPER_RST      = 8'h00;
  localparam logic [7:0] DERR_RST      = 8'h00;
  localparam logic [6:0] FIFO_DEPTH    = 7'h40;
  localparam logic [6:0] RUN_MAX       = 7'h7f;
  localparam logic [6:0] RUN_CODE_MIN  = 7'h02;

  typedef enum logic [1:0] {
    FL_IDLE = 2'b00,
    FL_CODE = 2'b01,
    FL_BYTE = 2'b11,
    FL_REP  = 2'b10
  } pfs_flush_t;

endpackage

// >>> pfs_fifo_ctrl.sv
`timescale 1ns/1ps
module pfs_fifo_ctrl
  import pfs_pkg::*;
#(
  parameter int TICK_CYCLES = STALE_TICK_CYC
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        ecp_mode,
  input  wire logic        pe_rx_valid,
  input  wire logic [7:0]  pe_rx_data,
  input  wire logic        pe_rx_tag,
  output logic             pe_rx_ready,
  output logic             pe_tx_valid,
  output logic [7:0]       pe_tx_data,
  output logic             pe_tx_tag,
  input  wire logic        pe_tx_ready,
  input  wire logic        pe_burst_end,
  input  wire logic [7:0]  data_err_set,
  output logic             dma_req,
  input  wire logic        dma_ack,
  input  wire logic [15:0] dma_wdata,
  output logic [15:0]      dma_rdata,
  output logic             host_irq
);

  function automatic logic [6:0] fifo_level(input logic d, input logic [6:0] c);
    return d ? FIFO_DEPTH - c : c;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [8:0]  mem [64];
  logic [5:0]  wp_r, rp_r;
  logic [6:0]  cnt_r, cnt_nxt;
  logic [7:0]  ctrl_r, pacc_r, sper_r, derr_r, scnt_r;
  logic [6:0]  thr_r, run_r;
  logic [7:0]  h1_r, h2_r, pend_b_r;
  logic        v1_r, v2_r, t1_r, t2_r, pend_v_r, flush_req_r;
  logic        stale_r, stale_prev_r, to_pend_r, timeout_r, lone_hold_r;
  logic [13:0] presc_r;
  logic        rx_ready_r, tx_valid_r, tx_tag_r, dma_req_r, irq_r, hready_r;
  logic [7:0]  tx_data_r;
  logic [15:0] dma_rdata_r;
  logic [31:0] hrdata_r;
  logic        wr_pend_r, rd_pend_r, addr_ok_r;
  logic [7:0]  idx_r;
  pfs_flush_t  fl_r, fl_nxt;

  // ------------------------------------------------------------
  // bus slave: writes take no wait, reads take one wait state
  // ------------------------------------------------------------
  logic ap, wr_c, rd_c;
  assign ap   = hsel && hready && htrans[1];
  assign wr_c = wr_pend_r && addr_ok_r;
  assign rd_c = rd_pend_r && addr_ok_r;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_ok_r <= 1'b0;
      idx_r     <= 8'h00;
      hready_r  <= 1'b1;
    end
    else
    begin
      wr_pend_r <= ap && hwrite;
      rd_pend_r <= ap && !hwrite;
      if (ap)
      begin
        idx_r     <= haddr[9:2];
        addr_ok_r <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
      end
      // the wait cycle lets hrdata_r load from rd_mux before the read data is taken
      hready_r  <= !(ap && !hwrite);
    end

  logic [7:0] status_w, rd_mux;
  logic       empty, full, tagf, lone, rle_on, dir, fifo_reset_p, clr_to;
  assign dir    = ctrl_r[CTL_DIR];
  assign empty  = (cnt_r == 7'h00);
  assign full   = (cnt_r == FIFO_DEPTH);
  assign tagf   = (v1_r && t1_r) || (v2_r && t2_r);
  assign lone   = !dir && empty && stale_r && v2_r && !v1_r;
  assign rle_on = ctrl_r[CTL_RLE] && ecp_mode;
  // status is pure decode of other state, so 0x40 follows reset by itself
  assign status_w = {full, empty, timeout_r, tagf, v1_r || v2_r, stale_r, lone, |derr_r};
  assign fifo_reset_p = wr_c && (idx_r == IDX_CTRL) && hwdata[CTL_FRES];
  assign clr_to = wr_c && (idx_r == IDX_PACC) && (hwdata[PACC_CLR_TO] != pacc_r[PACC_CLR_TO]);

  always_comb
  begin
    unique case (idx_r)
      IDX_CTRL:   rd_mux = {1'b0, 2'h0, ctrl_r[4:0]};
      IDX_PACC:   rd_mux = pacc_r;
      IDX_STATUS: rd_mux = status_w;
      IDX_DERR:   rd_mux = derr_r;
      IDX_HOLD1:  rd_mux = h1_r;
      IDX_HOLD2:  rd_mux = h2_r;
      IDX_RUN:    rd_mux = {1'b0, run_r};
      IDX_LEVEL:  rd_mux = {1'b0, fifo_level(dir, cnt_r)};
      IDX_THR:    rd_mux = {1'b0, thr_r};
      IDX_SPER:   rd_mux = sper_r;
      default:    rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hrdata_r <= 32'h00000000;
    else if (rd_pend_r)
      hrdata_r <= addr_ok_r ? {24'h000000, rd_mux} : 32'h00000000;

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ctrl_r <= CTRL_RST;
      pacc_r <= PACC_RST;
      thr_r  <= THR_RST;
      sper_r <= SPER_RST;
    end
    else if (wr_c)
    begin
      if (idx_r == IDX_CTRL) ctrl_r <= {1'b0, 2'h0, hwdata[4:0]};
      if (idx_r == IDX_PACC) pacc_r <= hwdata[7:0];
      if (idx_r == IDX_THR)  thr_r  <= hwdata[6:0];
      if (idx_r == IDX_SPER) sper_r <= hwdata[7:0];
    end

  // write one to clear; a new error in the same cycle stays set
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      derr_r <= DERR_RST;
    else
      derr_r <= (derr_r & ~((wr_c && idx_r == IDX_DERR) ? hwdata[7:0] : 8'h00)) | data_err_set;

  // ------------------------------------------------------------
  // pipeline movement
  // ------------------------------------------------------------
  logic [8:0] head;
  logic rx_div, rx_ld1, ld1_host, mv12, rep, rd1, rd2, dma_rd, dma_wr, h2_take;
  logic rx_wr, tx_pop, tx_w;
  logic [8:0] tx_wd;
  assign head     = mem[rp_r];
  assign rd1      = rd_c && (idx_r == IDX_HOLD1);
  assign rd2      = rd_c && (idx_r == IDX_HOLD2);
  assign rx_div   = !dir && rle_on && !empty && head[8] && !head[7] && (run_r == RUN_RST) && !v1_r;
  assign rx_ld1   = !dir && !empty && !v1_r && !rx_div && !lone_hold_r;
  assign ld1_host = dir && wr_c && (idx_r == IDX_HOLD1) && !v1_r;
  assign mv12     = v1_r && !v2_r && !rd1;
  assign rep      = mv12 && !dir && rle_on && (run_r != RUN_RST);
  assign dma_rd   = !dir && dma_ack && dma_req_r && v1_r && v2_r && !t1_r && !t2_r;
  assign dma_wr   = dir && dma_ack && dma_req_r && !v1_r && !v2_r;
  assign rx_wr    = !dir && pe_rx_valid && rx_ready_r && !full;
  assign tx_pop   = dir && !empty && (!tx_valid_r || pe_tx_ready);

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      {v1_r, v2_r, t1_r, t2_r} <= 4'h0;
      h1_r <= 8'h00;
      h2_r <= 8'h00;
    end
    else if (fifo_reset_p)
      {v1_r, v2_r, t1_r, t2_r} <= 4'h0;
    else
    begin
      if (dma_rd || rd2 || h2_take)
        {v2_r, t2_r} <= 2'h0;
      else if (dma_wr)
      begin
        h2_r <= dma_wdata[7:0];
        {v2_r, t2_r} <= 2'h2;
      end
      else if (mv12)
      begin
        h2_r <= h1_r;
        {v2_r, t2_r} <= {1'b1, t1_r};
      end
      // a repeating run keeps its byte in stage one
      if (dma_rd || rd1 || (mv12 && !rep))
        {v1_r, t1_r} <= 2'h0;
      else if (rx_ld1)
      begin
        h1_r <= head[7:0];
        {v1_r, t1_r} <= {1'b1, head[8]};
      end
      else if (ld1_host)
      begin
        h1_r <= hwdata[7:0];
        {v1_r, t1_r} <= {1'b1, ctrl_r[CTL_SET_TAG]};
      end
      else if (dma_wr)
      begin
        h1_r <= dma_wdata[15:8];
        {v1_r, t1_r} <= 2'h2;
      end
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      dma_rdata_r <= 16'h0000;
    else if (dma_rd)
      dma_rdata_r <= {h1_r, h2_r};

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      lone_hold_r <= 1'b0;
    else if (fifo_reset_p || !v2_r)
      lone_hold_r <= 1'b0;
    else if (lone)
      lone_hold_r <= 1'b1;

  // ------------------------------------------------------------
  // transmit run-length compression
  // ------------------------------------------------------------
  always_comb
  begin
    tx_w    = 1'b0;
    tx_wd   = 9'h000;
    h2_take = 1'b0;
    fl_nxt  = fl_r;
    if (dir && !full)
      unique case (fl_r)
        FL_IDLE:
          if (v2_r)
          begin
            if (!rle_on)
            begin
              tx_w    = 1'b1;
              tx_wd   = {t2_r, h2_r};
              h2_take = 1'b1;
            end
            else if (pend_v_r && (t2_r || h2_r != pend_b_r || run_r == RUN_MAX))
              fl_nxt = (run_r >= RUN_CODE_MIN) ? FL_CODE : FL_BYTE;
            else if (t2_r)
            begin
              tx_w    = 1'b1;
              tx_wd   = {1'b1, h2_r};
              h2_take = 1'b1;
            end
            else
              h2_take = 1'b1;
          end
          else if (pend_v_r && flush_req_r)
            fl_nxt = (run_r >= RUN_CODE_MIN) ? FL_CODE : FL_BYTE;
        FL_CODE:
        begin
          tx_w   = 1'b1;
          tx_wd  = {1'b1, 1'b0, run_r};
          fl_nxt = FL_BYTE;
        end
        FL_BYTE:
        begin
          tx_w   = 1'b1;
          tx_wd  = {1'b0, pend_b_r};
          fl_nxt = (run_r == 7'h01) ? FL_REP : FL_IDLE;
        end
        FL_REP:
        begin
          tx_w   = 1'b1;
          tx_wd  = {1'b0, pend_b_r};
          fl_nxt = FL_IDLE;
        end
      endcase
  end

  logic absorb;
  assign absorb = h2_take && rle_on && !t2_r && fl_r == FL_IDLE;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      fl_r        <= FL_IDLE;
      pend_v_r    <= 1'b0;
      pend_b_r    <= 8'h00;
      flush_req_r <= 1'b0;
    end
    else if (fifo_reset_p)
    begin
      fl_r        <= FL_IDLE;
      pend_v_r    <= 1'b0;
      flush_req_r <= 1'b0;
    end
    else
    begin
      fl_r <= fl_nxt;
      if (fl_r != FL_IDLE && fl_nxt == FL_IDLE)
        pend_v_r <= 1'b0;
      else if (absorb && !pend_v_r)
      begin
        pend_v_r <= 1'b1;
        pend_b_r <= h2_r;
      end
      if (pe_burst_end)
        flush_req_r <= 1'b1;
      else if (!pend_v_r)
        flush_req_r <= 1'b0;
    end

  // run count: transmit run length or receive repeat count
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      run_r <= RUN_RST;
    else if (fifo_reset_p)
      run_r <= RUN_RST;
    else if (wr_c && idx_r == IDX_RUN)
      run_r <= hwdata[6:0];
    else if (rx_div)
      run_r <= head[6:0];
    else if (rep)
      run_r <= run_r - 7'h01;
    else if (fl_r != FL_IDLE && fl_nxt == FL_IDLE)
      run_r <= RUN_RST;
    else if (absorb && pend_v_r)
      run_r <= run_r + 7'h01;

  // ------------------------------------------------------------
  // FIFO storage and level
  // ------------------------------------------------------------
  logic fw, fr;
  assign fw = rx_wr || tx_w;
  assign fr = rx_ld1 || rx_div || tx_pop;
  assign cnt_nxt = fifo_reset_p ? 7'h00 : cnt_r + {6'h00, fw} - {6'h00, fr};

  always_ff @(posedge hclk)
    if (fw)
      mem[wp_r] <= rx_wr ? {pe_rx_tag, pe_rx_data} : tx_wd;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wp_r       <= 6'h00;
      rp_r       <= 6'h00;
      cnt_r      <= 7'h00;
      rx_ready_r <= 1'b0;
    end
    else
    begin
      wp_r       <= fifo_reset_p ? 6'h00 : wp_r + {5'h00, fw};
      rp_r       <= fifo_reset_p ? 6'h00 : rp_r + {5'h00, fr};
      cnt_r      <= cnt_nxt;
      rx_ready_r <= !dir && (cnt_nxt != FIFO_DEPTH);
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      tx_valid_r <= 1'b0;
      tx_data_r  <= 8'h00;
      tx_tag_r   <= 1'b0;
    end
    else if (fifo_reset_p)
      tx_valid_r <= 1'b0;
    else if (tx_pop)
    begin
      tx_valid_r <= 1'b1;
      {tx_tag_r, tx_data_r} <= head;
    end
    else if (pe_tx_ready)
      tx_valid_r <= 1'b0;

  // ------------------------------------------------------------
  // stale timer and timeout
  // ------------------------------------------------------------
  logic tick;
  assign tick = (presc_r == 14'(TICK_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      presc_r <= 14'h0000;
      scnt_r  <= 8'h00;
      stale_r <= 1'b0;
    end
    else if (fifo_reset_p)
    begin
      presc_r <= 14'h0000;
      scnt_r  <= 8'h00;
      stale_r <= 1'b0;
    end
    else if (rx_wr)
    begin
      // reloading also restarts the prescaler so short periods stay accurate
      presc_r <= 14'h0000;
      scnt_r  <= sper_r;
      stale_r <= 1'b0;
    end
    else
    begin
      presc_r <= tick ? 14'h0000 : presc_r + 14'h0001;
      if (tick && scnt_r != 8'h00)
        scnt_r <= scnt_r - 8'h01;
      if (dir)
        stale_r <= 1'b0;
      else if (tick && scnt_r == 8'h01)
        stale_r <= 1'b1;
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      stale_prev_r <= 1'b0;
      to_pend_r    <= 1'b0;
      timeout_r    <= 1'b0;
    end
    else
    begin
      stale_prev_r <= stale_r;
      if (stale_r && !stale_prev_r)
        to_pend_r <= 1'b1;
      else if (to_pend_r && (dir || (empty && !dma_req_r)))
        to_pend_r <= 1'b0;
      if (to_pend_r && (dir || (empty && !dma_req_r)))
        timeout_r <= 1'b1;
      else if (fifo_reset_p || clr_to)
        timeout_r <= 1'b0;
    end

  // ------------------------------------------------------------
  // DMA request and host interrupt
  // ------------------------------------------------------------
  logic [7:0] avail;
  logic [6:0] lvl;
  assign lvl   = fifo_level(dir, cnt_r);
  assign avail = dir ? {1'b0, lvl} : {1'b0, cnt_r} + {7'h00, v1_r} + {7'h00, v2_r};

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      dma_req_r <= 1'b0;
    else
      dma_req_r <= ctrl_r[CTL_DMA_EN] && !fifo_reset_p && (avail >= 8'h02) &&
                   (dma_req_r || (lvl >= thr_r) || (!dir && stale_r && v1_r && v2_r));

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      irq_r <= 1'b0;
    else
      irq_r <= (ctrl_r[CTL_TAG_IE] && tagf) || lone || timeout_r;

  assign hreadyout   = hready_r;
  assign hresp       = 1'b0;
  assign hrdata      = hrdata_r;
  assign pe_rx_ready = rx_ready_r;
  assign pe_tx_valid = tx_valid_r;
  assign pe_tx_data  = tx_data_r;
  assign pe_tx_tag   = tx_tag_r;
  assign dma_req     = dma_req_r;
  assign dma_rdata   = dma_rdata_r;
  assign host_irq    = irq_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence rd_addr_s;
    ap && !hwrite;
  endsequence
  sequence rd_wait_s;
    !hready_r ##1 hready_r;
  endsequence

  chk_full_blocks_rx: assert property ((cnt_r == FIFO_DEPTH) |-> status_w[ST_FULL] && !rx_ready_r)
    else $error("full FIFO still accepts bytes");
  chk_empty_fall: assert property ($fell(status_w[ST_EMPTY]) |-> $past(fw))
    else $error("empty flag fell without a FIFO write");
  chk_timeout_wait: assert property ($rose(timeout_r) |-> $past(to_pend_r) && ($past(dir) || $past(empty)))
    else $error("timeout set before FIFO drained");
  chk_timeout_hold: assert property (timeout_r && !fifo_reset_p && !clr_to |=> timeout_r)
    else $error("timeout cleared without software action");
  chk_tag_irq: assert property (ctrl_r[CTL_TAG_IE] && tagf |=> irq_r)
    else $error("tagged byte raised no interrupt");
  chk_lone_block: assert property (lone_hold_r && !v1_r |=> !v1_r)
    else $error("stage one loaded while lone byte held");
  chk_dma_cause: assert property ($rose(dma_req_r) |-> $past(ctrl_r[CTL_DMA_EN]) &&
                                  ($past(lvl >= thr_r) || $past(stale_r)))
    else $error("DMA request without threshold or stale");
  chk_run_decr: assert property (rep |=> (run_r == $past(run_r) - 7'h01) && v1_r)
    else $error("run repeat did not decrement");
  chk_rle_gate: assert property ($changed(run_r) && run_r != RUN_RST && !$past(wr_c) |-> $past(rle_on))
    else $error("run count moved with coding off");
  chk_stale_reload: assert property (rx_wr && !fifo_reset_p |=> scnt_r == $past(sper_r) && !stale_r)
    else $error("stale counter not reloaded");
  chk_read_wait: assert property (rd_addr_s |=> rd_wait_s)
    else $error("read did not take one wait state");

endmodule

// >>> pfs_dma_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// dma controller stand-in
// ------------------------------------------------------------
module pfs_dma_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        dma_req,
  output logic             dma_ack,
  output logic [15:0]      dma_wdata,
  output logic             word_vld
);
  int   gap_r;
  logic took_r;
  assign dma_wdata = 16'h0000;
  // read word stands the cycle after the ack
  assign word_vld = took_r;
  // whole words only; the gap lets both stages refill before the next ack
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dma_ack <= 1'b0;
      took_r <= 1'b0;
      gap_r <= 0;
    end
    else
    begin
      took_r <= dma_ack;
      if (dma_ack)
      begin
        dma_ack <= 1'b0;
        gap_r <= 4 + $urandom_range(0, 3);
      end
      else if (gap_r > 0)
        gap_r <= gap_r - 1;
      else
        dma_ack <= dma_req;
    end
  end
endmodule

// >>> parallel_fifo_status_dma_rle_tb.sv
`timescale 1ns/1ps
module parallel_fifo_status_dma_rle_tb;
  import pfs_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, ecp_mode = 0, rd_ph = 0;
  logic        pe_rx_valid = 0, pe_rx_tag = 0, pe_tx_ready = 1, pe_burst_end = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  pe_rx_data = 0, data_err_set = 0, pe_tx_data;
  logic        hreadyout, hresp, pe_rx_ready, pe_tx_valid, pe_tx_tag, dma_req, dma_ack, host_irq, word_vld;
  logic [15:0] dma_wdata, dma_rdata;
  logic [31:0] exp_q[$];
  logic [15:0] wexp_q[$];
  logic [8:0]  txq[$];
  string       nm_q[$];
  int          mismatches = 0, total_checks = 0;

  always #5 hclk = ~hclk;

  pfs_fifo_ctrl #(.TICK_CYCLES(8)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ecp_mode(ecp_mode), .pe_rx_valid(pe_rx_valid),
    .pe_rx_data(pe_rx_data), .pe_rx_tag(pe_rx_tag), .pe_rx_ready(pe_rx_ready), .pe_tx_valid(pe_tx_valid),
    .pe_tx_data(pe_tx_data), .pe_tx_tag(pe_tx_tag), .pe_tx_ready(pe_tx_ready), .pe_burst_end(pe_burst_end),
    .data_err_set(data_err_set), .dma_req(dma_req), .dma_ack(dma_ack), .dma_wdata(dma_wdata),
    .dma_rdata(dma_rdata), .host_irq(host_irq));

  pfs_dma_model dma (.hclk(hclk), .hresetn(hresetn), .dma_req(dma_req), .dma_ack(dma_ack),
    .dma_wdata(dma_wdata), .word_vld(word_vld));

  // ------------------------------------------------------------
  // bus, link and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] d);
    @(posedge hclk);
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    rd_ph <= !wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string n);
    exp_q.push_back({24'h0, e});
    nm_q.push_back(n);
    bus(idx, 1'b0, 8'h00);
  endtask

  task automatic rx(input logic [7:0] d, input logic t);
    @(posedge hclk);
    pe_rx_valid <= 1'b1;
    pe_rx_data <= d;
    pe_rx_tag <= t;
    do @(posedge hclk); while (pe_rx_ready !== 1'b1);
    pe_rx_valid <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // results are compared against the oldest note as they appear
  always @(posedge hclk)
  begin
    if (rd_ph && hreadyout === 1'b1)
      chk(nm_q.pop_front(), exp_q.pop_front(), hrdata);
    if (word_vld === 1'b1)
      chk("dma word", {16'h0, wexp_q.pop_front()}, {16'h0, dma_rdata});
    if (pe_tx_valid === 1'b1 && pe_tx_ready === 1'b1)
      chk("tx byte", {23'h0, txq.pop_front()}, {23'h0, pe_tx_tag, pe_tx_data});
  end

  initial
  begin
    repeat (5000) @(posedge hclk);
    mismatches++;
    report_and_stop();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    logic [7:0] b, p, e;
    logic [6:0] thr;
    void'($urandom(32'hef634355));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(IDX_STATUS, 8'h40, "status");
    rd(IDX_THR, 8'h00, "threshold");
    rd(IDX_RUN, 8'h00, "run count");
    bus(IDX_STATUS, 1'b1, 8'hff);
    rd(IDX_STATUS, 8'h40, "status");
    rd(8'h33, 8'h00, "unmapped");
    $display("test reset done");
    e = 8'($urandom_range(1, 255));
    @(posedge hclk);
    data_err_set <= e;
    @(posedge hclk);
    data_err_set <= 8'h00;
    rd(IDX_STATUS, 8'h41, "status");
    bus(IDX_DERR, 1'b1, e);
    rd(IDX_STATUS, 8'h40, "status");
    $display("test data error done");
    thr = 7'($urandom_range(2, 60));
    bus(IDX_THR, 1'b1, {1'b0, thr});
    bus(IDX_RUN, 1'b1, 8'hff);
    rd(IDX_RUN, 8'h7f, "run count");
    bus(IDX_CTRL, 1'b1, 8'h80);
    rd(IDX_RUN, 8'h00, "run count");
    rd(IDX_THR, {1'b0, thr}, "threshold");
    rd(IDX_LEVEL, 8'h00, "level");
    $display("test fifo reset done");
    for (int i = 0; i < 66; i++)
    begin
      b = 8'($urandom);
      rx(b, 1'b0);
      if (i[0])
        wexp_q.push_back({b, p});
      p = b;
      if (i == 1)
      begin
        rd(IDX_STATUS, 8'h48, "status");
        rd(IDX_LEVEL, 8'h00, "level");
      end
    end
    rd(IDX_LEVEL, 8'h40, "level");
    rd(IDX_STATUS, 8'h88, "status");
    $display("test fill done");
    bus(IDX_CTRL, 1'b1, 8'h01);
    while (wexp_q.size() > 0)
      @(posedge hclk);
    repeat (8) @(posedge hclk);
    chk("dma request", 32'h0, {31'h0, dma_req});
    rd(IDX_STATUS, 8'h40, "status");
    $display("test dma drain done");
    bus(IDX_CTRL, 1'b1, 8'h11);
    b = 8'($urandom);
    rx(b, 1'b1);
    rd(IDX_STATUS, 8'h58, "status");
    chk("host irq", 32'h1, {31'h0, host_irq});
    rd(IDX_HOLD2, b, "stage two");
    rd(IDX_STATUS, 8'h40, "status");
    $display("test tag done");
    // transmit: a run of three collapses to a code and one copy, the odd byte waits for burst end
    ecp_mode <= 1'b1;
    bus(IDX_CTRL, 1'b1, 8'h8a);
    rd(IDX_LEVEL, 8'h40, "level");
    b = 8'($urandom);
    p = b ^ 8'($urandom_range(1, 255));
    txq.push_back(9'h102);
    txq.push_back({1'b0, b});
    txq.push_back({1'b0, p});
    repeat (3) bus(IDX_HOLD1, 1'b1, b);
    rd(IDX_RUN, 8'h02, "run count");
    bus(IDX_HOLD1, 1'b1, p);
    repeat (8) @(posedge hclk);
    pe_burst_end <= 1'b1;
    @(posedge hclk);
    pe_burst_end <= 1'b0;
    while (txq.size() > 0)
      @(posedge hclk);
    rd(IDX_LEVEL, 8'h40, "level");
    $display("test transmit run done");
    // stale with one byte left: lone byte, timeout, stage one held back
    bus(IDX_CTRL, 1'b1, 8'h80);
    bus(IDX_SPER, 1'b1, 8'h02);
    b = 8'($urandom);
    rx(b, 1'b0);
    repeat (40) @(posedge hclk);
    rd(IDX_STATUS, 8'h6e, "status");
    chk("host irq", 32'h1, {31'h0, host_irq});
    bus(IDX_SPER, 1'b1, 8'h00);
    p = 8'($urandom);
    rx(p, 1'b0);
    rd(IDX_LEVEL, 8'h01, "level");
    rd(IDX_STATUS, 8'h28, "status");
    rd(IDX_HOLD2, b, "stage two");
    bus(IDX_PACC, 1'b1, 8'h08);
    rd(IDX_STATUS, 8'h48, "status");
    chk("host irq", 32'h0, {31'h0, host_irq});
    rd(IDX_HOLD2, p, "stage two");
    $display("test stale done");
    // receive: a code of two gives three copies out of stage two
    bus(IDX_CTRL, 1'b1, 8'h88);
    rx(8'h02, 1'b1);
    e = 8'($urandom);
    rx(e, 1'b0);
    rd(IDX_RUN, 8'h01, "run count");
    repeat (3) rd(IDX_HOLD2, e, "stage two");
    rd(IDX_STATUS, 8'h40, "status");
    $display("test receive run done");
    report_and_stop();
  end
endmodule
